// file: src/eecfg_pkg.sv
// eecfg_pkg: constants and types for the edge event source configuration block
// assumes a single core clock and synchronous active-low reset
`default_nettype none
package eecfg_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;
	typedef logic [ADDR_W-1:0] eecfg_addr_t;
	typedef logic [DATA_W-1:0] eecfg_data_t;
	typedef logic [3:0] eecfg_sel_t;
	typedef logic [1:0] eecfg_irq_t;

	// register offsets
	localparam eecfg_addr_t OFF_CONTROL = 8'h00;
	localparam eecfg_addr_t OFF_IRQ_STATUS = 8'h04;
	localparam eecfg_addr_t OFF_IRQ_CLEAR = 8'h08;
	localparam eecfg_addr_t OFF_IRQ_ENABLE = 8'h0C;

	// control field positions
	localparam int unsigned POS_ONE_MODE = 15;
	localparam int unsigned POS_ONE_POL = 14;
	localparam int unsigned POS_ONE_SEL = 10;
	localparam int unsigned POS_TWO_STAT = 9;
	localparam int unsigned POS_ONE_STAT = 8;
	localparam int unsigned POS_TWO_MODE = 7;
	localparam int unsigned POS_TWO_POL = 6;
	localparam int unsigned POS_TWO_SEL = 2;

	// interrupt status bit positions
	localparam int unsigned POS_IRQ_ONE = 0;
	localparam int unsigned POS_IRQ_TWO = 1;

	// reset values
	localparam eecfg_sel_t RST_SEL = 4'h0;
	localparam logic RST_BIT = 1'b0;
	localparam eecfg_irq_t RST_IRQ = 2'h0;
	localparam eecfg_data_t RST_DATA = 16'h0000;
	localparam logic [2:0] RST_SYNC = 3'h0;

	// source select codes
	typedef enum logic [3:0] {
		SRC_TIMER_ONE = 4'b0000,
		SRC_COMPARE = 4'b0001,
		SRC_PIN_TWO = 4'b0010,
		SRC_PIN_ONE = 4'b0011,
		SRC_PIN_THREE = 4'b0100,
		SRC_PIN_FOUR = 4'b0101,
		SRC_PIN_FIVE = 4'b0110,
		SRC_PIN_SIX = 4'b0111,
		SRC_CAPTURE_ONE = 4'b1010,
		SRC_CAPTURE_TWO = 4'b1011,
		SRC_CAPTURE_THREE = 4'b1100,
		SRC_COMP_ONE = 4'b1101,
		SRC_COMP_TWO = 4'b1110,
		SRC_COMP_THREE = 4'b1111
	} eecfg_src_t;
endpackage : eecfg_pkg
`default_nettype wire

// file: src/eecfg_edge_if.sv
// eecfg_edge_if: settings of one edge input and its detected event
// assumes the main module drives settings and a detector answers with hit
`default_nettype none
interface eecfg_edge_if;
	logic mode;
	logic pol;
	logic [3:0] sel;
	logic hit;
	modport cfg (output mode, output pol, output sel, input hit);
	modport det (input mode, input pol, input sel, output hit);
endinterface : eecfg_edge_if
`default_nettype wire

// file: src/eecfg_sync.sv
// eecfg_sync: three-flop synchroniser for external edge pins
// assumes pins are asynchronous to the core clock
`default_nettype none
module eecfg_sync (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [5:0] pin_i,
	output logic [5:0] pin_o
);
	import eecfg_pkg::*;
	logic [5:0] s1_q, s2_q, s3_q, out_q;
	logic [5:0] out_d;

	// a change counts once the second and third flops agree
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s1_q <= 6'h00;
			s2_q <= 6'h00;
			s3_q <= 6'h00;
			out_q <= 6'h00;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out_q <= out_d;
		end
	end

	assign pin_o = out_q;
endmodule : eecfg_sync
`default_nettype wire

// file: src/eecfg_edge.sv
// eecfg_edge: picks one source by code and detects its edge or level
// assumes the source vector is on the core clock, indexed by select code
`default_nettype none
module eecfg_edge (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [15:0] src_i,
	eecfg_edge_if.det edge_if
);
	import eecfg_pkg::*;
	logic picked;
	logic prev_q, prev_d;

	always_comb begin
		picked = src_i[edge_if.sel];
		prev_d = picked;
		if (edge_if.mode) begin
			// edge sensitive: rising when pol set, falling otherwise
			edge_if.hit = edge_if.pol ? (picked & ~prev_q) : (~picked & prev_q);
		end else begin
			// level sensitive: active level follows pol
			edge_if.hit = (picked == edge_if.pol);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			prev_q <= RST_BIT;
		end else begin
			prev_q <= prev_d;
		end
	end
endmodule : eecfg_edge
`default_nettype wire

// file: src/eecfg_top.sv
// eecfg_top: edge event source configuration with control register and interrupt
// assumes a plain register port, on-chip sources on the core clock, pins asynchronous
// Overview of operation
// - edge one mode bit 15: one means transitions, zero means level
// - edge one polarity bit 14: one rising or high level, zero falling or low level response
// - bits 13..10 select the source for edge one
// - codes 1111, 1110, 1101 pick comparator three, two, one outputs
// - codes 1100, 1011, 1010 pick capture channel three, two, one
// - code 0000 timer one, 0010 pin two, 0111 pin six
// - status bits read one after their edge; writes steer current source
//
// Added by the designer: strobed register access and the register addresses.
`default_nettype none
module eecfg_top (
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire eecfg_pkg::eecfg_addr_t REG_ADDR_I,
	input wire eecfg_pkg::eecfg_data_t REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output eecfg_pkg::eecfg_data_t REG_RDATA_O,
	input wire logic TIMER_ONE_EVENT_I,
	input wire logic COMPARE_OUT_I,
	input wire logic [2:0] COMP_OUT_I,
	input wire logic [2:0] CAPTURE_I,
	input wire logic [5:0] EXT_EDGE_PIN_I,
	output logic EDGE_ONE_STATUS_O,
	output logic EDGE_TWO_STATUS_O,
	output logic CURRENT_SOURCE_ON_O,
	output logic IRQ_O
);
	import eecfg_pkg::*;

	logic one_mode_q, one_mode_d;
	logic one_pol_q, one_pol_d;
	eecfg_sel_t one_sel_q, one_sel_d;
	logic two_mode_q, two_mode_d;
	logic two_pol_q, two_pol_d;
	eecfg_sel_t two_sel_q, two_sel_d;
	logic one_stat_q, one_stat_d;
	logic two_stat_q, two_stat_d;
	eecfg_irq_t irq_stat_q, irq_stat_d;
	eecfg_irq_t irq_en_q, irq_en_d;
	eecfg_data_t rdata_q, rdata_d;
	logic [5:0] pin_sync;
	logic [15:0] src_vec;
	logic ctrl_wr;
	eecfg_irq_t events;

	eecfg_edge_if one_if ();
	eecfg_edge_if two_if ();

	eecfg_sync u_sync (
		.clk_i(CORE_CLK_I),
		.rst_n_i(RST_N_I),
		.pin_i(EXT_EDGE_PIN_I),
		.pin_o(pin_sync)
	);

	// source vector indexed by select code
	always_comb begin
		src_vec = 16'h0000;
		src_vec[SRC_TIMER_ONE] = TIMER_ONE_EVENT_I;
		src_vec[SRC_COMPARE] = COMPARE_OUT_I;
		src_vec[SRC_PIN_TWO] = pin_sync[1];
		src_vec[SRC_PIN_ONE] = pin_sync[0];
		src_vec[SRC_PIN_THREE] = pin_sync[2];
		src_vec[SRC_PIN_FOUR] = pin_sync[3];
		src_vec[SRC_PIN_FIVE] = pin_sync[4];
		src_vec[SRC_PIN_SIX] = pin_sync[5];
		src_vec[SRC_CAPTURE_ONE] = CAPTURE_I[0];
		src_vec[SRC_CAPTURE_TWO] = CAPTURE_I[1];
		src_vec[SRC_CAPTURE_THREE] = CAPTURE_I[2];
		src_vec[SRC_COMP_ONE] = COMP_OUT_I[0];
		src_vec[SRC_COMP_TWO] = COMP_OUT_I[1];
		src_vec[SRC_COMP_THREE] = COMP_OUT_I[2];
	end

	assign one_if.mode = one_mode_q;
	assign one_if.pol = one_pol_q;
	assign one_if.sel = one_sel_q;
	assign two_if.mode = two_mode_q;
	assign two_if.pol = two_pol_q;
	assign two_if.sel = two_sel_q;

	eecfg_edge u_edge_one (
		.clk_i(CORE_CLK_I),
		.rst_n_i(RST_N_I),
		.src_i(src_vec),
		.edge_if(one_if)
	);

	eecfg_edge u_edge_two (
		.clk_i(CORE_CLK_I),
		.rst_n_i(RST_N_I),
		.src_i(src_vec),
		.edge_if(two_if)
	);

	assign ctrl_wr = REG_WR_I && (REG_ADDR_I == OFF_CONTROL);
	assign events = {two_if.hit, one_if.hit};

	// control fields
	always_comb begin
		one_mode_d = one_mode_q;
		one_pol_d = one_pol_q;
		one_sel_d = one_sel_q;
		two_mode_d = two_mode_q;
		two_pol_d = two_pol_q;
		two_sel_d = two_sel_q;
		if (ctrl_wr) begin
			one_mode_d = REG_WDATA_I[POS_ONE_MODE];
			one_pol_d = REG_WDATA_I[POS_ONE_POL];
			one_sel_d = REG_WDATA_I[POS_ONE_SEL +: 4];
			two_mode_d = REG_WDATA_I[POS_TWO_MODE];
			two_pol_d = REG_WDATA_I[POS_TWO_POL];
			two_sel_d = REG_WDATA_I[POS_TWO_SEL +: 4];
		end
	end

	// edge status: software write, then detected edge wins
	always_comb begin
		one_stat_d = one_stat_q;
		two_stat_d = two_stat_q;
		if (ctrl_wr) begin
			one_stat_d = REG_WDATA_I[POS_ONE_STAT];
			two_stat_d = REG_WDATA_I[POS_TWO_STAT];
		end
		if (one_if.hit) begin
			one_stat_d = 1'b1;
		end
		if (two_if.hit) begin
			two_stat_d = 1'b1;
		end
	end

	// interrupt status, clear and enable
	always_comb begin
		irq_stat_d = irq_stat_q;
		irq_en_d = irq_en_q;
		if (REG_WR_I && (REG_ADDR_I == OFF_IRQ_CLEAR)) begin
			irq_stat_d = irq_stat_q & ~REG_WDATA_I[1:0];
		end
		if (REG_WR_I && (REG_ADDR_I == OFF_IRQ_ENABLE)) begin
			irq_en_d = REG_WDATA_I[1:0];
		end
		irq_stat_d = irq_stat_d | events;
	end

	// read data, valid only in the cycle after the strobe
	always_comb begin
		rdata_d = RST_DATA;
		if (REG_RD_I) begin
			case (REG_ADDR_I)
				OFF_CONTROL: begin
					rdata_d[POS_ONE_MODE] = one_mode_q;
					rdata_d[POS_ONE_POL] = one_pol_q;
					rdata_d[POS_ONE_SEL +: 4] = one_sel_q;
					rdata_d[POS_TWO_STAT] = two_stat_q;
					rdata_d[POS_ONE_STAT] = one_stat_q;
					rdata_d[POS_TWO_MODE] = two_mode_q;
					rdata_d[POS_TWO_POL] = two_pol_q;
					rdata_d[POS_TWO_SEL +: 4] = two_sel_q;
				end
				OFF_IRQ_STATUS: begin
					rdata_d[1:0] = irq_stat_q;
				end
				OFF_IRQ_ENABLE: begin
					rdata_d[1:0] = irq_en_q;
				end
				default: begin
					rdata_d = RST_DATA;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			one_mode_q <= RST_BIT;
			one_pol_q <= RST_BIT;
			one_sel_q <= RST_SEL;
			two_mode_q <= RST_BIT;
			two_pol_q <= RST_BIT;
			two_sel_q <= RST_SEL;
			one_stat_q <= RST_BIT;
			two_stat_q <= RST_BIT;
			irq_stat_q <= RST_IRQ;
			irq_en_q <= RST_IRQ;
			rdata_q <= RST_DATA;
		end else begin
			one_mode_q <= one_mode_d;
			one_pol_q <= one_pol_d;
			one_sel_q <= one_sel_d;
			two_mode_q <= two_mode_d;
			two_pol_q <= two_pol_d;
			two_sel_q <= two_sel_d;
			one_stat_q <= one_stat_d;
			two_stat_q <= two_stat_d;
			irq_stat_q <= irq_stat_d;
			irq_en_q <= irq_en_d;
			rdata_q <= rdata_d;
		end
	end

	assign REG_RDATA_O = rdata_q;
	assign EDGE_ONE_STATUS_O = one_stat_q;
	assign EDGE_TWO_STATUS_O = two_stat_q;
	// source charges between edge one and edge two
	assign CURRENT_SOURCE_ON_O = one_stat_q ^ two_stat_q;
	assign IRQ_O = |(irq_stat_q & irq_en_q);
endmodule : eecfg_top
`default_nettype wire

// file: bench/eecfg_src_model.sv
// eecfg_src_model: on-chip and pin edge sources, indexed by select code
// assumes the bench picks one source and sets its level
`default_nettype none
module eecfg_src_model (
	input wire logic clk_i,
	input wire logic [3:0] code_i,
	input wire logic lvl_i,
	output logic [15:0] src_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// unselected sources sit low
	always_ff @(posedge clk_i) begin
		src_o <= 16'(lvl_i) << code_i;
	end
endmodule : eecfg_src_model
`default_nettype wire

// file: bench/eecfg_top_sva.sv
// eecfg_top_sva: port checks of the edge source block
// assumes binding into eecfg_top, same-clock sources only
`default_nettype none
module eecfg_top_sva (
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	input wire eecfg_pkg::eecfg_addr_t REG_ADDR_I,
	input wire eecfg_pkg::eecfg_data_t REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire eecfg_pkg::eecfg_data_t REG_RDATA_O,
	input wire logic TIMER_ONE_EVENT_I,
	input wire logic COMPARE_OUT_I,
	input wire logic [2:0] COMP_OUT_I,
	input wire logic [2:0] CAPTURE_I,
	input wire logic EDGE_ONE_STATUS_O,
	input wire logic EDGE_TWO_STATUS_O,
	input wire logic CURRENT_SOURCE_ON_O
);
	import eecfg_pkg::*;
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);
	eecfg_data_t ctl_q;
	logic prev_q;
	logic cur;
	logic [15:0] sv;
	logic wc;
	assign sv = {COMP_OUT_I, CAPTURE_I, 8'h00, COMPARE_OUT_I, TIMER_ONE_EVENT_I};
	assign cur = sv[ctl_q[13:10]];
	assign wc = REG_WR_I && REG_ADDR_I == OFF_CONTROL;
	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_N_I) begin
			ctl_q <= 16'h0000;
		end else if (wc) begin
			ctl_q <= REG_WDATA_I;
		end
		prev_q <= cur;
	end
	property p_rise;
		ctl_q[15:14] == 2'b11 && $stable(ctl_q) && !prev_q && cur |=> EDGE_ONE_STATUS_O;
	endproperty
	a_rise: assert property (p_rise) else $error("rising source missed");
	property p_fall;
		ctl_q[15:14] == 2'b10 && $stable(ctl_q) && prev_q && !cur |=> EDGE_ONE_STATUS_O;
	endproperty
	a_fall: assert property (p_fall) else $error("falling source missed");
	property p_level;
		ctl_q[15:14] == 2'b01 && cur |=> EDGE_ONE_STATUS_O;
	endproperty
	a_level: assert property (p_level) else $error("level source missed");
	property p_sticky;
		EDGE_ONE_STATUS_O && !wc |=> EDGE_ONE_STATUS_O;
	endproperty
	a_sticky: assert property (p_sticky) else $error("status dropped");
	property p_wr_stat;
		wc |=> EDGE_ONE_STATUS_O >= $past(REG_WDATA_I[8]) && EDGE_TWO_STATUS_O >= $past(REG_WDATA_I[9]);
	endproperty
	a_wr_stat: assert property (p_wr_stat) else $error("status write lost");
	property p_cur;
		CURRENT_SOURCE_ON_O == (EDGE_ONE_STATUS_O ^ EDGE_TWO_STATUS_O);
	endproperty
	a_cur: assert property (p_cur) else $error("current source wrong");
	property p_rd_idle;
		!$past(REG_RD_I) |-> REG_RDATA_O == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_rd_ctl;
		REG_RD_I && REG_ADDR_I == OFF_CONTROL |=>
			{REG_RDATA_O[15:10], REG_RDATA_O[7:0]} == {$past(ctl_q[15:10]), $past(ctl_q[7:2]), 2'b00};
	endproperty
	a_rd_ctl: assert property (p_rd_ctl) else $error("control readback wrong");
endmodule : eecfg_top_sva
bind eecfg_top eecfg_top_sva i_eecfg_top_sva (.CORE_CLK_I, .RST_N_I, .REG_ADDR_I, .REG_WDATA_I,
	.REG_WR_I, .REG_RD_I, .REG_RDATA_O, .TIMER_ONE_EVENT_I, .COMPARE_OUT_I, .COMP_OUT_I,
	.CAPTURE_I, .EDGE_ONE_STATUS_O, .EDGE_TWO_STATUS_O, .CURRENT_SOURCE_ON_O);
`default_nettype wire

// file: bench/testbench.sv
// testbench: edge source block through its register port and sources
// assumes eecfg_src_model as far side and the bound checker
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import eecfg_pkg::*;
	logic clk, rst_n, wr, rd, lvl, st1, st2, cur, irq;
	eecfg_addr_t addr;
	eecfg_data_t wdata, rdata;
	logic [3:0] code;
	logic [15:0] src;
	int num_errors = 0;
	int comparisons = 0;
	eecfg_src_model i_eecfg_src_model (.clk_i(clk), .code_i(code), .lvl_i(lvl), .src_o(src));
	eecfg_top i_eecfg_top (.CORE_CLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr),
		.REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
		.TIMER_ONE_EVENT_I(src[0]), .COMPARE_OUT_I(src[1]), .COMP_OUT_I(src[15:13]),
		.CAPTURE_I(src[12:10]), .EXT_EDGE_PIN_I({src[7:4], src[2], src[3]}),
		.EDGE_ONE_STATUS_O(st1), .EDGE_TWO_STATUS_O(st2), .CURRENT_SOURCE_ON_O(cur), .IRQ_O(irq));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr_reg(input eecfg_addr_t a, input eecfg_data_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input eecfg_addr_t a, input eecfg_data_t d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		check(rdata, d);
	endtask : rd_chk
	task automatic rise(input logic [3:0] c, input logic v);
		@(posedge clk);
		code <= c;
		lvl <= v;
	endtask : rise
	task automatic t_reset;
		rd_chk(OFF_CONTROL, 16'h0300);
		rd_chk(OFF_IRQ_STATUS, 16'h0003);
		rd_chk(OFF_IRQ_ENABLE, 16'h0000);
		rd_chk(OFF_IRQ_CLEAR, 16'h0000);
		rd_chk(8'h10, 16'h0000);
		check(irq, 1'b0);
		$display("reset test done");
	endtask : t_reset
	task automatic t_sources;
		logic [3:0] codes[9] = '{4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'hA, 4'h0, 4'h2, 4'h7};
		wr_reg(OFF_IRQ_ENABLE, 16'h0001);
		wr_reg(OFF_CONTROL, 16'hC000);
		foreach (codes[i]) begin
			rise(codes[i], 1'b0);
			wr_reg(OFF_CONTROL, {2'b11, codes[i], 10'h000});
			wr_reg(OFF_IRQ_CLEAR, 16'h0001);
			@(negedge clk);
			check(st1, 1'b0);
			check(irq, 1'b0);
			rise(codes[i], 1'b1);
			for (int k = 0; k < 8 && st1 !== 1'b1; k++) @(negedge clk);
			check(st1, 1'b1);
			check(irq, 1'b1);
			rd_chk(OFF_CONTROL, {2'b11, codes[i], 2'b11, 8'h00});
			rd_chk(OFF_IRQ_STATUS, 16'h0003);
			rise(codes[i], 1'b0);
			wr_reg(OFF_IRQ_CLEAR, 16'h0001);
			@(negedge clk) check(irq, 1'b0);
		end
		$display("source test done");
	endtask : t_sources
	task automatic t_pol;
		rise(4'hC, 1'b1);
		wr_reg(OFF_CONTROL, 16'hB000);
		@(negedge clk);
		check(st1, 1'b0);
		rise(4'hC, 1'b0);
		for (int k = 0; k < 8 && st1 !== 1'b1; k++) @(negedge clk);
		check(st1, 1'b1);
		wr_reg(OFF_CONTROL, 16'h7000);
		@(negedge clk) check(st1, 1'b0);
		rise(4'hC, 1'b1);
		repeat (3) @(negedge clk);
		check(st1, 1'b1);
		$display("polarity test done");
	endtask : t_pol
	task automatic t_two;
		rise(4'hD, 1'b0);
		wr_reg(OFF_CONTROL, 16'h40F7);
		wr_reg(OFF_CONTROL, 16'h40F7);
		rd_chk(OFF_CONTROL, 16'h40F4);
		check(cur, 1'b0);
		rise(4'hD, 1'b1);
		for (int k = 0; k < 8 && st2 !== 1'b1; k++) @(negedge clk);
		check(st2, 1'b1);
		check(cur, 1'b1);
		wr_reg(OFF_CONTROL, 16'h43F4);
		rd_chk(OFF_CONTROL, 16'h43F4);
		check(cur, 1'b0);
		$display("edge two test done");
	endtask : t_two
	task automatic tally_and_finish;
		$display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		{rst_n, wr, rd, lvl} = 4'h0;
		addr = 8'h00;
		wdata = 16'h0000;
		code = 4'h0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_sources();
		t_pol();
		t_two();
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
